// ---- design/rts_params.svh ----
// constants for the resistive touch sequencer: offsets, fields, resets, timing
`ifndef RTS_PARAMS_SVH
`define RTS_PARAMS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define RTS_OFS_CTRL 5'h00
`define RTS_OFS_SETTLE 5'h04
`define RTS_OFS_STATUS 5'h08
`define RTS_OFS_XPOS 5'h0c
`define RTS_OFS_YPOS 5'h10
`define RTS_OFS_XSCALE 5'h14
`define RTS_OFS_YSCALE 5'h18

// ************************************************************
// field positions and reset values
// ************************************************************
`define RTS_CTRL_EN 0
`define RTS_CTRL_MODE_LO 1
`define RTS_CTRL_MODE_HI 2
`define RTS_CTRL_WID_LO 3
`define RTS_CTRL_WID_HI 4
`define RTS_ST_WAKE 0
`define RTS_ST_SLEEP 1
`define RTS_ST_NEW 2
`define RTS_CTRL_RST 32'h0000_0008
`define RTS_WID_8 2'h0
`define RTS_WID_10 2'h1
`define RTS_WID_12 2'h2
`define RTS_MODE_4W 2'h0
`define RTS_MODE_5W 2'h1
`define RTS_MODE_8W 2'h2

// ************************************************************
// electrode indices (five-wire reuses 0..4)
// ************************************************************
`define RTS_PAD_XP 0
`define RTS_PAD_XN 1
`define RTS_PAD_YP 2
`define RTS_PAD_YN 3
`define RTS_PAD_YPS 4
`define RTS_PAD_YNS 5
`define RTS_PAD_XPS 6
`define RTS_PAD_XNS 7
`define RTS_PAD_UL 0
`define RTS_PAD_UR 1
`define RTS_PAD_LL 2
`define RTS_PAD_LR 3
`define RTS_PAD_SNS 4
`define RTS_NPADS 8

// ************************************************************
// timing
// ************************************************************
`define RTS_CLK_NS 10
`define RTS_SETTLE_NS 1000
`define RTS_SETTLE_CYC ((`RTS_SETTLE_NS + `RTS_CLK_NS - 1) / `RTS_CLK_NS)
`define RTS_NSAMP 5
`define RTS_LAST_REP 3'h4
`define RTS_SYNC_LAT 16'h0003 // pad lag, two sync stages, edge detect

`endif

// ---- design/rts_pkg.sv ----
// types shared by the resistive touch sequencer
package rts_pkg;
   typedef enum logic [3:0] {
      ST_OFF, ST_ARM, ST_SLEEP, ST_SETTLE, ST_START, ST_WAIT,
      ST_MEDIAN, ST_PUBLISH, ST_CHECK
   } rts_state_t;
   typedef enum logic [1:0] {PH_FLOAT, PH_WAKE, PH_Y, PH_X} rts_phase_t;
endpackage : rts_pkg

// ---- design/rts_median5.sv ----
// five-sample window with combinational median pick
`timescale 1ns/100ps
`default_nettype none
`include "rts_params.svh"
module rts_median5
   import rts_pkg::*;
#(
   parameter int DW = 12
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // sample stream
   input wire logic push,
   input wire logic [DW-1:0] sample,
   // result
   output logic [DW-1:0] median
);
   logic [DW-1:0] win_r [`RTS_NSAMP];
   logic [`RTS_NSAMP-1:0] isMed;

   // shift window of the last five conversions
   always_ff @(posedge clk) begin
      if (!resetn) begin
         for (int i = 0; i < `RTS_NSAMP; i++) win_r[i] <= '0;
      end else if (push) begin
         win_r[0] <= sample;
         for (int i = 1; i < `RTS_NSAMP; i++) win_r[i] <= win_r[i-1];
      end
   end

   // rank each entry; ties broken by index so exactly one has rank two
   genvar g;
   generate
      for (g = 0; g < `RTS_NSAMP; g++) begin : gRank
         always_comb begin
            int cnt;
            cnt = 0;
            for (int j = 0; j < `RTS_NSAMP; j++) begin
               if (win_r[j] < win_r[g] || (win_r[j] == win_r[g] && j < g))
                  cnt++;
            end
            isMed[g] = (cnt == 2);
         end
      end
   endgenerate

   // select the middle entry
   always_comb begin
      median = '0;
      for (int i = 0; i < `RTS_NSAMP; i++) begin
         if (isMed[i]) median = win_r[i];
      end
   end
endmodule : rts_median5
`default_nettype wire

// ---- design/rts_sequencer.sv ----
// resistive touch panel electrode sequencer with avalon-mm register slave
// Functional notes
// - four-wire vertical: y positive electrode high, y negative low
// - vertical: x negative floats unpulled, x positive routed to converter
// - full scale follows converter width; 12-bit gives 4096 counts
// - panel scale equals full scale: raw result forwarded unchanged
// - horizontal: drive x pair, sample one y electrode, other y floats
// - four-wire wake arm: x positive becomes pulled-up wake input
// - four-wire wake: x negative, y positive unpulled inputs, y negative low
// - wake input responds to falling edge of x positive before sleep
// - pen-down low on wake pin raises wake event, leaves sleep, measures
// - keep reading until pen-up seen, then re-arm wake and sleep
// - eight-wire: separate conversions on positive and negative y sense pads
// - eight-wire: sense difference replaces nominal full scale
// - eight-wire: x sense pair and its difference for the horizontal axis
// - five-wire horizontal: right pads high, left pads low, convert sense
// - five-wire vertical: upper pads high, lower pads low, convert sense
// - five-wire wake: three corners float, fourth pulled wake, sense low
// - five-wire pen-down pulling wake corner low triggers wake event
// - conversion width defaults to 10 bits; 8 and 12 selectable
// - configurable settling delay before conversion, zero allowed
// - five consecutive conversions per coordinate, median reported
`timescale 1ns/100ps
`default_nettype none
`include "rts_params.svh"
module rts_sequencer
   import rts_pkg::*;
#(
   parameter int DW = 12,
   parameter logic [15:0] SETTLE_RST = 16'(`RTS_SETTLE_CYC)
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // avalon-mm register slave
   input wire logic [4:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWritedata,
   input wire logic [3:0] avsByteenable,
   output logic [31:0] avsReaddata,
   output logic avsWaitrequest,
   // panel electrodes
   input wire logic [`RTS_NPADS-1:0] padIn,
   output logic [`RTS_NPADS-1:0] padOut,
   output logic [`RTS_NPADS-1:0] padOe,
   output logic [`RTS_NPADS-1:0] padPullUp,
   // converter
   output logic adcStart,
   output logic [2:0] adcChannel,
   output logic [1:0] adcWidth,
   input wire logic adcDone,
   input wire logic [DW-1:0] adcData,
   // status to system
   output logic wakeEvent,
   output logic sleeping
);
   // ************************************************************
   // registers and state
   // ************************************************************
   logic [31:0] ctrl_r;
   logic [15:0] settle_r;
   logic wakeFlag_r, newFlag_r;
   logic [DW-1:0] xPos_r, yPos_r, senseP_r, sample_r;
   logic [DW:0] xScale_r, yScale_r;
   rts_state_t state_r;
   logic axis_r; // 0 vertical, 1 horizontal
   logic [1:0] step_r; // 0 main, 1 positive sense, 2 negative sense
   logic [2:0] rep_r;
   logic [15:0] cnt_r;
   logic [`RTS_NPADS-1:0] padMeta_r, padSync_r;
   logic wakePrev_r, penDown;
   logic push;
   logic [DW-1:0] median, dataMasked;
   logic [DW:0] fullScale;
   logic enable;
   logic [1:0] mode, wid;
   logic wrAcc, rdAcc;
   logic [31:0] rdMux;
   rts_phase_t phase;
   logic [`RTS_NPADS-1:0] cfgOe, cfgOut, cfgPull;
   logic [2:0] cfgCh;

   assign enable = ctrl_r[`RTS_CTRL_EN];
   assign mode = ctrl_r[`RTS_CTRL_MODE_HI:`RTS_CTRL_MODE_LO];
   assign wid = ctrl_r[`RTS_CTRL_WID_HI:`RTS_CTRL_WID_LO];

   // ************************************************************
   // avalon slave: one wait cycle, then the request completes
   // ************************************************************
   assign wrAcc = avsWrite && !avsWaitrequest;
   assign rdAcc = avsRead && !avsWaitrequest;

   // waitrequest drops for exactly one cycle per request
   always_ff @(posedge clk) begin
      if (!resetn) begin
         avsWaitrequest <= 1'b1;
      end else begin
         avsWaitrequest <= !((avsRead || avsWrite) && avsWaitrequest);
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      rdMux = '0;
      unique case (avsAddress)
         `RTS_OFS_CTRL: rdMux = ctrl_r;
         `RTS_OFS_SETTLE: rdMux = {16'h0000, settle_r};
         `RTS_OFS_STATUS: begin
            rdMux[`RTS_ST_WAKE] = wakeFlag_r;
            rdMux[`RTS_ST_SLEEP] = sleeping;
            rdMux[`RTS_ST_NEW] = newFlag_r;
         end
         `RTS_OFS_XPOS: rdMux[DW-1:0] = xPos_r;
         `RTS_OFS_YPOS: rdMux[DW-1:0] = yPos_r;
         `RTS_OFS_XSCALE: rdMux[DW:0] = xScale_r;
         `RTS_OFS_YSCALE: rdMux[DW:0] = yScale_r;
         default: rdMux = '0;
      endcase
   end

   // read data loaded with the cycle that drops waitrequest
   always_ff @(posedge clk) begin
      if (!resetn) begin
         avsReaddata <= '0;
      end else if (avsRead && avsWaitrequest) begin
         avsReaddata <= rdMux;
      end
   end

   // byte-lane merge for writable registers
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) res[8*b +: 8] = wd[8*b +: 8];
      end
      return res;
   endfunction : merge

   // control register: enable, panel type, converter width
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl_r <= `RTS_CTRL_RST;
      end else if (wrAcc && avsAddress == `RTS_OFS_CTRL) begin
         ctrl_r <= merge(ctrl_r, avsWritedata, avsByteenable) &
                   32'h0000_001f;
      end
   end

   // settling delay in clock cycles
   always_ff @(posedge clk) begin
      if (!resetn) begin
         settle_r <= SETTLE_RST;
      end else if (wrAcc && avsAddress == `RTS_OFS_SETTLE) begin
         settle_r <= 16'(merge({16'h0000, settle_r}, avsWritedata,
                               avsByteenable));
      end
   end

   // ************************************************************
   // pad input synchroniser and wake edge detect
   // ************************************************************
   always_ff @(posedge clk) begin
      if (!resetn) begin
         padMeta_r <= '1;
         padSync_r <= '1;
         wakePrev_r <= 1'b1;
      end else begin
         padMeta_r <= padIn;
         padSync_r <= padMeta_r;
         wakePrev_r <= padSync_r[`RTS_PAD_XP];
      end
   end

   // falling edge on the pulled-up wake pad (x positive or upper left)
   assign penDown = wakePrev_r && !padSync_r[`RTS_PAD_XP];

   // ************************************************************
   // converter data handling
   // ************************************************************
   // keep only the selected width; full scale is two to the width
   always_comb begin
      dataMasked = adcData;
      fullScale = '0;
      unique case (wid)
         `RTS_WID_8: begin
            dataMasked = adcData & DW'(12'h0ff);
            fullScale = (DW+1)'(13'h0100);
         end
         `RTS_WID_12: begin
            fullScale = (DW+1)'(13'h1000);
         end
         default: begin
            dataMasked = adcData & DW'(12'h3ff);
            fullScale = (DW+1)'(13'h0400);
         end
      endcase
   end

   assign push = (state_r == ST_WAIT) && adcDone && (step_r == 2'h0);

   rts_median5 #(
      .DW(DW)
   ) uMedian (
      .clk(clk),
      .resetn(resetn),
      .push(push),
      .sample(dataMasked),
      .median(median)
   );

   // ************************************************************
   // sequencer state machine
   // ************************************************************
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_r <= ST_OFF;
         axis_r <= 1'b0;
         step_r <= 2'h0;
         rep_r <= '0;
         cnt_r <= '0;
      end else if (!enable) begin
         state_r <= ST_OFF;
      end else begin
         unique case (state_r)
            ST_OFF: begin
               cnt_r <= '0;
               state_r <= ST_ARM;
            end
            ST_ARM: begin
               // wake pattern settles before the edge detector is trusted
               if (cnt_r >= settle_r && cnt_r >= `RTS_SYNC_LAT) begin
                  state_r <= ST_SLEEP;
               end else begin
                  cnt_r <= cnt_r + 16'h0001;
               end
            end
            ST_SLEEP: begin
               if (penDown) begin
                  axis_r <= 1'b0;
                  step_r <= 2'h0;
                  rep_r <= '0;
                  cnt_r <= '0;
                  state_r <= ST_SETTLE;
               end
            end
            ST_SETTLE: begin
               if (cnt_r >= settle_r) begin
                  state_r <= ST_START;
               end else begin
                  cnt_r <= cnt_r + 16'h0001;
               end
            end
            ST_START: begin
               state_r <= ST_WAIT;
            end
            ST_WAIT: begin
               if (adcDone) begin
                  cnt_r <= '0;
                  if (step_r != 2'h0) begin
                     // eight-wire sense pair
                     if (step_r == 2'h1) begin
                        step_r <= 2'h2;
                        state_r <= ST_SETTLE;
                     end else if (!axis_r) begin
                        axis_r <= 1'b1;
                        step_r <= 2'h0;
                        state_r <= ST_SETTLE;
                     end else begin
                        state_r <= ST_PUBLISH;
                     end
                  end else if (rep_r == `RTS_LAST_REP) begin
                     rep_r <= '0;
                     state_r <= ST_MEDIAN;
                  end else begin
                     rep_r <= rep_r + 3'h1;
                     state_r <= ST_START;
                  end
               end
            end
            ST_MEDIAN: begin
               cnt_r <= '0;
               if (mode == `RTS_MODE_8W) begin
                  step_r <= 2'h1;
                  state_r <= ST_SETTLE;
               end else if (!axis_r) begin
                  axis_r <= 1'b1;
                  state_r <= ST_SETTLE;
               end else begin
                  state_r <= ST_PUBLISH;
               end
            end
            ST_PUBLISH: begin
               // pen-up test uses the pulled-up wake pattern
               cnt_r <= '0;
               state_r <= ST_CHECK;
            end
            ST_CHECK: begin
               // never sample a stale drive level still in the synchroniser
               if (cnt_r < settle_r || cnt_r < `RTS_SYNC_LAT) begin
                  cnt_r <= cnt_r + 16'h0001;
               end else if (padSync_r[`RTS_PAD_XP]) begin
                  cnt_r <= '0;
                  state_r <= ST_ARM;
               end else begin
                  axis_r <= 1'b0;
                  step_r <= 2'h0;
                  cnt_r <= '0;
                  state_r <= ST_SETTLE;
               end
            end
         endcase
      end
   end

   // ************************************************************
   // result capture
   // ************************************************************
   always_ff @(posedge clk) begin
      if (!resetn) begin
         xPos_r <= '0;
         yPos_r <= '0;
         senseP_r <= '0;
         sample_r <= '0;
         xScale_r <= '0;
         yScale_r <= '0;
      end else if (state_r == ST_MEDIAN) begin
         // raw median forwarded, no scaling arithmetic
         if (axis_r) xPos_r <= median;
         else yPos_r <= median;
         if (axis_r) xScale_r <= fullScale;
         else yScale_r <= fullScale;
      end else if (state_r == ST_WAIT && adcDone) begin
         sample_r <= dataMasked;
         if (step_r == 2'h1) senseP_r <= dataMasked;
         if (step_r == 2'h2) begin
            // sense difference overrides nominal scale
            if (axis_r) xScale_r <= {1'b0, senseP_r - dataMasked};
            else yScale_r <= {1'b0, senseP_r - dataMasked};
         end
      end
   end

   // status flags: hardware set wins over a write-one clear
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wakeFlag_r <= 1'b0;
         newFlag_r <= 1'b0;
      end else begin
         if (state_r == ST_SLEEP && penDown) begin
            wakeFlag_r <= 1'b1;
         end else if (wrAcc && avsAddress == `RTS_OFS_STATUS &&
                      avsByteenable[0] && avsWritedata[`RTS_ST_WAKE]) begin
            wakeFlag_r <= 1'b0;
         end
         if (state_r == ST_PUBLISH) begin
            newFlag_r <= 1'b1;
         end else if (wrAcc && avsAddress == `RTS_OFS_STATUS &&
                      avsByteenable[0] && avsWritedata[`RTS_ST_NEW]) begin
            newFlag_r <= 1'b0;
         end
      end
   end

   // ************************************************************
   // electrode configuration
   // ************************************************************
   always_comb begin
      unique case (state_r)
         ST_OFF: phase = PH_FLOAT;
         ST_ARM, ST_SLEEP, ST_PUBLISH, ST_CHECK: phase = PH_WAKE;
         default: phase = axis_r ? PH_X : PH_Y;
      endcase
   end

   // drive pattern per panel type and phase; undriven pads float
   always_comb begin
      cfgOe = '0;
      cfgOut = '0;
      cfgPull = '0;
      cfgCh = 3'(`RTS_PAD_XP);
      if (mode == `RTS_MODE_5W) begin
         unique case (phase)
            PH_WAKE: begin
               cfgPull[`RTS_PAD_UL] = 1'b1;
               cfgOe[`RTS_PAD_SNS] = 1'b1;
            end
            PH_X: begin
               cfgOe[`RTS_PAD_UL] = 1'b1;
               cfgOe[`RTS_PAD_LL] = 1'b1;
               cfgOe[`RTS_PAD_UR] = 1'b1;
               cfgOe[`RTS_PAD_LR] = 1'b1;
               cfgOut[`RTS_PAD_UR] = 1'b1;
               cfgOut[`RTS_PAD_LR] = 1'b1;
               cfgCh = 3'(`RTS_PAD_SNS);
            end
            PH_Y: begin
               cfgOe[`RTS_PAD_UL] = 1'b1;
               cfgOe[`RTS_PAD_LL] = 1'b1;
               cfgOe[`RTS_PAD_UR] = 1'b1;
               cfgOe[`RTS_PAD_LR] = 1'b1;
               cfgOut[`RTS_PAD_UL] = 1'b1;
               cfgOut[`RTS_PAD_UR] = 1'b1;
               cfgCh = 3'(`RTS_PAD_SNS);
            end
            PH_FLOAT: cfgCh = 3'(`RTS_PAD_SNS);
         endcase
      end else begin
         unique case (phase)
            PH_WAKE: begin
               cfgPull[`RTS_PAD_XP] = 1'b1;
               cfgOe[`RTS_PAD_YN] = 1'b1;
            end
            PH_Y: begin
               cfgOe[`RTS_PAD_YP] = 1'b1;
               cfgOut[`RTS_PAD_YP] = 1'b1;
               cfgOe[`RTS_PAD_YN] = 1'b1;
               cfgCh = 3'(`RTS_PAD_XP);
               if (step_r == 2'h1) cfgCh = 3'(`RTS_PAD_YPS);
               if (step_r == 2'h2) cfgCh = 3'(`RTS_PAD_YNS);
            end
            PH_X: begin
               cfgOe[`RTS_PAD_XP] = 1'b1;
               cfgOut[`RTS_PAD_XP] = 1'b1;
               cfgOe[`RTS_PAD_XN] = 1'b1;
               cfgCh = 3'(`RTS_PAD_YP);
               if (step_r == 2'h1) cfgCh = 3'(`RTS_PAD_XPS);
               if (step_r == 2'h2) cfgCh = 3'(`RTS_PAD_XNS);
            end
            PH_FLOAT: cfgCh = 3'(`RTS_PAD_XP);
         endcase
      end
   end

   // ************************************************************
   // registered outputs
   // ************************************************************
   always_ff @(posedge clk) begin
      if (!resetn) begin
         padOe <= '0;
         padOut <= '0;
         padPullUp <= '0;
         adcChannel <= '0;
         adcWidth <= `RTS_WID_10;
      end else begin
         padOe <= cfgOe;
         padOut <= cfgOut;
         padPullUp <= cfgPull;
         adcChannel <= cfgCh;
         adcWidth <= wid;
      end
   end

   // one-cycle strobes and sleep level
   always_ff @(posedge clk) begin
      if (!resetn) begin
         adcStart <= 1'b0;
         wakeEvent <= 1'b0;
         sleeping <= 1'b0;
      end else begin
         adcStart <= (state_r == ST_START);
         wakeEvent <= enable && (state_r == ST_SLEEP) && penDown;
         sleeping <= (state_r == ST_SLEEP);
      end
   end
endmodule : rts_sequencer
`default_nettype wire

// ---- testbench/rts_properties.sv ----
// port checker for the touch sequencer
`timescale 1ns/100ps
`default_nettype none
module rts_properties (
   // clock, reset and bus
   input wire logic clk,
   input wire logic resetn,
   input wire logic [4:0] avsAddress,
   input wire logic avsWrite,
   input wire logic [31:0] avsWritedata,
   input wire logic avsWaitrequest,
   // electrodes, converter and status
   input wire logic [7:0] padOut,
   input wire logic [7:0] padOe,
   input wire logic [7:0] padPullUp,
   input wire logic adcStart,
   input wire logic [2:0] adcChannel,
   input wire logic wakeEvent,
   input wire logic sleeping
);
   logic [1:0] mode_r;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // shadow of the panel mode field
   always_ff @(posedge clk) begin
      if (!resetn) mode_r <= 2'h0;
      else if (avsWrite && !avsWaitrequest && avsAddress == 5'h00)
         mode_r <= avsWritedata[2:1];
   end
   a_start_single: assert property (adcStart |=> !adcStart)
      else $error("long start pulse");
   a_wake_leaves: assert property (wakeEvent |->
      sleeping ##1 !sleeping) else $error("wake without leaving sleep");
   a_wake_reads: assert property (wakeEvent |-> ##[1:200] adcStart)
      else $error("no conversion after wake");
   a_arm_pin: assert property (sleeping |-> padPullUp[0] && !padOe[0])
      else $error("wake pin not armed");
   a_arm_four: assert property (sleeping && mode_r == 2'h0 |->
      padOe[3:0] == 4'h8 && !padOut[3] && padPullUp[2:1] == 2'h0)
      else $error("four-wire wake pattern");
   a_arm_five: assert property (sleeping && mode_r == 2'h1 |->
      padOe[4:0] == 5'h10 && !padOut[4] && padPullUp[3:1] == 3'h0)
      else $error("five-wire wake pattern");
   a_vert_four: assert property (adcStart && mode_r == 2'h0
      && adcChannel == 3'h0 |-> padOe[3:0] == 4'hc && padOut[3:2] == 2'h1
      && padPullUp[1:0] == 2'h0) else $error("vertical pattern");
   a_five_conv: assert property (adcStart && mode_r == 2'h1 |->
      adcChannel == 3'h4 && padOe[3:0] == 4'hf
      && (padOut[3:0] == 4'ha || padOut[3:0] == 4'h3))
      else $error("five-wire pattern");
endmodule : rts_properties
bind rts_sequencer rts_properties rts_properties_i (.clk, .resetn,
   .avsAddress, .avsWrite, .avsWritedata, .avsWaitrequest, .padOut, .padOe,
   .padPullUp, .adcStart, .adcChannel, .wakeEvent, .sleeping);
`default_nettype wire

// ---- testbench/rts_panel_model.sv ----
// panel electrodes and converter beside the sequencer
`timescale 1ns/100ps
`default_nettype none
module rts_panel_model (
   // bench controls
   input wire logic clk,
   input wire logic penDown,
   input wire logic slow,
   input wire logic spike,
   input wire logic [7:0][11:0] tbl,
   // sequencer side
   input wire logic [7:0] padOut,
   input wire logic [7:0] padOe,
   input wire logic [7:0] padPullUp,
   input wire logic adcStart,
   input wire logic [2:0] adcChannel,
   input wire logic [1:0] adcWidth,
   output logic [7:0] padIn,
   output logic adcDone,
   output logic [11:0] adcData
);
   logic tog_r = 1'b0;
   logic [2:0] cnt_r = 3'h0, nc_r = 3'h0;
   logic [11:0] val_r = 12'h0;
   // undriven unpulled pads show noise; the pen grounds the wake pad
   assign padIn[0] = padOe[0] ? padOut[0] : !penDown & (padPullUp[0] | tog_r);
   assign padIn[7:1] = padOe[7:1] & padOut[7:1]
      | ~padOe[7:1] & (padPullUp[7:1] | {7{tog_r}});
   // result valid only with done
   assign adcDone = cnt_r == 3'h1;
   assign adcData = adcDone ? val_r : ~val_r;
   // short or long conversion, one outlier in five when asked
   always @(posedge clk) begin
      tog_r <= ~tog_r;
      if (cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
      else if (adcStart) begin
         cnt_r <= slow ? 3'h7 : 3'h2;
         nc_r <= nc_r == 3'h4 ? 3'h0 : nc_r + 3'h1;
         if (spike && nc_r == 3'h2) val_r <= 12'hfff >> (4 - 2 * adcWidth);
         else if (adcChannel == 3'h4 && padOe[3] && padOut[3]) val_r <= tbl[1];
         else val_r <= tbl[adcChannel];
      end
   end
endmodule : rts_panel_model
`default_nettype wire

// ---- testbench/rts_sequencer_tb.sv ----
// self-checking bench for the touch sequencer
`timescale 1ns/100ps
`default_nettype none
module rts_sequencer_tb;
   logic clk = 1'b0, resetn = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
   logic [4:0] avsAddress = 5'h00;
   logic [31:0] avsWritedata = 32'h0, avsReaddata, seed = 32'ha5fe;
   logic avsWaitrequest, adcStart, adcDone, wakeEvent, sleeping;
   logic [7:0] padIn, padOut, padOe, padPullUp;
   logic [2:0] adcChannel;
   logic [1:0] adcWidth;
   logic [11:0] adcData;
   logic penDown = 1'b0, slow = 1'b0, spike = 1'b0;
   logic [7:0][11:0] tbl = '0;
   logic [31:0] expQ[$];
   int n_errors = 0, checked = 0;
   always #5 clk = ~clk;
   rts_sequencer #(.DW(12), .SETTLE_RST(16'h0002)) rts_sequencer_i (.clk,
      .resetn, .avsAddress, .avsRead, .avsWrite, .avsWritedata,
      .avsByteenable(4'hf), .avsReaddata, .avsWaitrequest, .padIn, .padOut,
      .padOe, .padPullUp, .adcStart, .adcChannel, .adcWidth, .adcDone,
      .adcData, .wakeEvent, .sleeping);
   rts_panel_model rts_panel_model_i (.clk, .penDown, .slow, .spike, .tbl,
      .padOut, .padOe, .padPullUp, .adcStart, .adcChannel, .adcWidth, .padIn,
      .adcDone, .adcData);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : check
   task automatic complete_run;
      if (expQ.size() != 0) n_errors++;
      if (n_errors == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : complete_run
   // bounded wait for count events: 0 wake, 1 sleep, 2 start
   task automatic await(input int what, input int cnt);
      int n, k;
      n = 0;
      k = 0;
      while (k < cnt && n < 4000) begin
         @(posedge clk);
         n++;
         if ({adcStart, sleeping, wakeEvent} >> what & 3'h1) k++;
      end
      if (n >= 4000) begin
         n_errors++;
         complete_run();
      end
   endtask : await
   // one bus cycle, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [4:0] a, logic [31:0] d);
      int n;
      n = 0;
      avsAddress <= a;
      avsWritedata <= d;
      avsWrite <= wr;
      avsRead <= !wr;
      @(posedge clk);
      while (avsWaitrequest !== 1'b0 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (n >= 50) begin
         n_errors++;
         complete_run();
      end
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      expQ.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask : rd
   // compare each read answer with the oldest note
   always @(posedge clk) begin
      if (avsRead && avsWaitrequest === 1'b0 && expQ.size() > 0)
         check(avsReaddata, expQ.pop_front());
   end
   initial begin
      logic [7:0][11:0] t;
      logic [31:0] m;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd(5'h00, 32'h8);
      check(32'(adcWidth), 32'h1);
      rd(5'h1c, 32'h0);
      for (int md = 0; md < 3; md++) begin
         for (int w = 0; w < 3; w++) begin
            m = (32'h1 << (8 + 2 * w)) - 32'h1;
            for (int e = 0; e < 8; e++) begin
               seed = lfsr(seed);
               t[e] = seed[11:0] & m[11:0];
            end
            t[3] = t[2];
            t[5] = t[4] >> 1;
            t[7] = t[6] >> 1;
            tbl <= t;
            slow <= seed[12];
            spike <= md != 2;
            bus(1'b1, 5'h04, 32'(md + 1));
            bus(1'b1, 5'h00, 32'(1 + md * 2 + w * 8));
            await(1, 1);
            penDown <= 1'b1;
            await(0, 1);
            await(2, 14);
            penDown <= 1'b0;
            await(1, 1);
            rd(5'h08, 32'h7);
            bus(1'b1, 5'h08, 32'h5);
            rd(5'h08, 32'h2);
            rd(5'h10, 32'(md == 1 ? t[4] : t[0]));
            rd(5'h0c, 32'(md == 1 ? t[1] : t[2]));
            rd(5'h18, md == 2 ? 32'(t[4] - t[5]) : m + 32'h1);
            rd(5'h14, md == 2 ? 32'(t[6] - t[7]) : m + 32'h1);
            bus(1'b1, 5'h00, 32'(md * 2 + w * 8));
         end
      end
      complete_run();
   end
endmodule : rts_sequencer_tb
`default_nettype wire
